// ---- sazd_pkg.sv ----
/*
 * Constants, register map and types shared by both ends of the serial audio link.
 * Assumes a single 25 MHz system clock that also serves as the master clock.
 */
// Behaviour
// [R01] Link is bit clock, word clock, serial data
// [R02] Device samples data on rising bit clock
// [R03] Word lengths 16/20/24/32, bit clock 32-64 fs
// [R04] Host master clock 128-3072 fs, at most 50 MHz
// [R05] Host keeps word clock synchronous to system clock
// [R06] Period drift over five clocks forces resync
// [R07] Bad bit-clock count over four periods resyncs
// [R08] Samples are two's complement, MSB first
// [R09] Format register, reset I2S with 24 bits
// [R10] Master mode drives bit and word clocks
// [R11] Mode bits 0,4,5; 7-bit and 8-bit dividers
// [R12] TDM frame starts on word clock rise
// [R13] Per-channel zero run counters, 3-bit thresholds
// [R14] Combine bit: clear OR, set AND
// [R15] Right enable bit, default on
// [R16] Left enable bit 0, default on
// [R17] Threshold codes map to run lengths table
// [R18] Mute at threshold, cleared by non-zero
// [R19] Resync gives zero samples and status bit
package sazd_pkg;

    // ========================================
    // Register indices, byte address is index times four
    localparam int         ADR_LSB   = 2;
    localparam logic [7:0] IDX_MCFG  = 8'h09;
    localparam logic [7:0] IDX_BDIV  = 8'h20;
    localparam logic [7:0] IDX_WDIV  = 8'h21;
    localparam logic [7:0] IDX_FMT   = 8'h28;
    localparam logic [7:0] IDX_THR   = 8'h3B;
    localparam logic [7:0] IDX_ZCTL  = 8'h41;
    localparam logic [7:0] IDX_STAT  = 8'h50;
    localparam logic [7:0] IDX_IRQ   = 8'h51;
    localparam logic [7:0] IDX_MASK  = 8'h52;

    // ========================================
    // Field positions
    localparam int MCFG_EN   = 0;
    localparam int MCFG_BOUT = 4;
    localparam int MCFG_WOUT = 5;
    localparam int FMT_LSB   = 4;
    localparam int WL_LSB    = 0;
    localparam int THR_L_LSB = 4;
    localparam int THR_R_LSB = 0;
    localparam int ZCTL_LEN  = 0;
    localparam int ZCTL_REN  = 1;
    localparam int ZCTL_AND  = 2;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_FMT  = 8'h02;
    localparam logic [7:0] RST_ZCTL = 8'h07;
    localparam logic [7:0] RST_THR  = 8'h00;
    localparam logic [6:0] RST_BDIV = 7'h01;
    localparam logic [7:0] RST_WDIV = 8'h3F;

    // ========================================
    // Formats and word lengths
    typedef enum logic [1:0] {
        SAZD_I2S = 2'h0,
        SAZD_LJ  = 2'h1,
        SAZD_RJ  = 2'h2,
        SAZD_TDM = 2'h3
    } sazd_fmt_t;
    localparam logic [5:0]  SAMP_W  = 6'h20;
    localparam logic [5:0]  WLEN [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
    localparam logic [18:0] ZTHR [8] = '{19'h00400, 19'h01400, 19'h02800, 19'h06400,
                                         19'h0C800, 19'h19000, 19'h3E800, 19'h7D000};
    localparam logic [18:0] ZCNT_MAX = 19'h7FFFF;

    // ========================================
    // Clock checking
    localparam logic [16:0] SYNC_TOL    = 17'h00005;
    localparam logic [15:0] PER_MAX     = 16'hFFFF;
    localparam logic [2:0]  INVALID_MAX = 3'h4;
    localparam logic [1:0]  RESYNC_GOOD = 2'h2;

    // ========================================
    // Host clock generation
    localparam logic [3:0] HOST_HALF  = 4'h2;
    localparam logic [5:0] HOST_WSH   = 6'h1F;
    localparam logic [6:0] HOST_HLEN0 = 7'h20;

endpackage : sazd_pkg

// ---- sazd_if.sv ----
/*
 * Three-wire audio link joining the device end and the host end.
 * Assumes at most one end enables each clock pin at a time.
 */
`timescale 1ns/100ps
interface sazd_if;
    logic bit_clock_dev;                 // Device bit clock drive
    logic bit_clock_dev_oe;
    logic word_sel_dev;                  // Device word clock drive
    logic word_sel_dev_oe;
    logic bit_clock_host;                // Host bit clock drive
    logic word_sel_host;                 // Host word clock drive
    logic serial_sample_input;           // Host data to device
    logic bit_clock;                     // Resolved bit clock
    logic word_select_frame_sync;        // Resolved word clock

    // Pin resolution from the enables
    assign bit_clock              = bit_clock_dev_oe ? bit_clock_dev : bit_clock_host;
    assign word_select_frame_sync = word_sel_dev_oe ? word_sel_dev : word_sel_host;

    modport dev (
        output bit_clock_dev, bit_clock_dev_oe, word_sel_dev, word_sel_dev_oe,
        input  serial_sample_input, bit_clock, word_select_frame_sync
    );
    modport host (
        output bit_clock_host, word_sel_host, serial_sample_input,
        input  bit_clock, word_select_frame_sync
    );
endinterface : sazd_if

// ---- sazd_zcnt.sv ----
/*
 * Consecutive zero-sample counter for one channel.
 * Assumes one tick per received sample of that channel.
 */
`timescale 1ns/100ps
module sazd_zcnt (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Sample stream
    input  wire logic       tick_i,
    input  wire logic       zero_i,
    input  wire logic       en_i,
    input  wire logic [2:0] code_i,
    // Threshold reached
    output logic            hit_o
);
    typedef struct packed {
        logic [18:0] cnt;
        logic        hit;
    } sazd_zc_st_t;

    sazd_zc_st_t q;
    sazd_zc_st_t n;

    // Count zero run, any non-zero sample restarts it
    always_comb
    begin
        n = q;
        if (!en_i)
            n.cnt = '0;
        else if (tick_i)
            n.cnt = zero_i ? ((q.cnt == sazd_pkg::ZCNT_MAX) ? q.cnt : q.cnt + 19'h00001)
                           : 19'h00000;                            // see [R13] see [R18]
        n.hit = en_i & (n.cnt >= sazd_pkg::ZTHR[code_i]);          // see [R17]
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q <= '0;
        else
            q <= n;
    end

    assign hit_o = q.hit;
endmodule : sazd_zcnt

// ---- sazd_dev.sv ----
/*
 * Device end: serial audio receiver with clock checking, bit and word clock
 * generation, zero detection and a classic Wishbone register slave.
 * Assumes link pins synchronous to sys_clk_i and bit clock at most a quarter of it.
 */
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
module sazd_dev (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Received samples and status
    output logic      [31:0] left_o,
    output logic      [31:0] right_o,
    output logic             sample_vld_o,
    output logic             mute_o,
    output logic             resync_o,
    // Audio link
    sazd_if.dev              lnk
);
    typedef struct packed {
        logic [7:0]  mcfg;
        logic [6:0]  bdiv;
        logic [7:0]  wdiv;
        logic [7:0]  fmt;
        logic [7:0]  thr;
        logic [7:0]  zctl;
        logic [1:0]  irq_st;
        logic [1:0]  mask;
        logic        ack;
        logic [7:0]  rdat;
        logic        irq;
        logic        bclk_l;
        logic        ws_l;
        logic        ws_b;
        logic [6:0]  bcnt;
        logic [31:0] shr;
        logic [31:0] left;
        logic [31:0] right;
        logic        tl;
        logic        tr;
        logic        vld;
        logic [15:0] per;
        logic [15:0] per_ref;
        logic [9:0]  bc;
        logic [9:0]  bc_ref;
        logic [2:0]  bad;
        logic [1:0]  good;
        logic        resync;
        logic        mute;
        logic [6:0]  gdiv;
        logic        gb;
        logic [7:0]  gw;
        logic        gws;
        logic        boe;
        logic        woe;
    } sazd_dev_st_t;

    localparam sazd_dev_st_t RST_ST = '{fmt: sazd_pkg::RST_FMT, thr: sazd_pkg::RST_THR,
                                        zctl: sazd_pkg::RST_ZCTL, bdiv: sazd_pkg::RST_BDIV,
                                        wdiv: sazd_pkg::RST_WDIV, bcnt: 7'h7F,
                                        resync: 1'b1, default: '0};

    sazd_dev_st_t        q;
    sazd_dev_st_t        n;
    sazd_pkg::sazd_fmt_t fmt;
    logic [5:0]          wl;
    logic [6:0]          wl7;
    logic [6:0]          cn;
    logic [31:0]         shn;
    logic [31:0]         src;
    logic [31:0]         word;
    logic [7:0]          idx;
    logic [1:0]          ev;
    logic                tdm;
    logic                brise;
    logic                wsr;
    logic                edg;
    logic                cap;
    logic                chl;
    logic                hit;
    logic                bad_s;
    logic                bad_b;
    logic                fault;
    logic                hit_l;
    logic                hit_r;
    logic                en_l;
    logic                en_r;

    // ========================================
    // Zero run counters, one per channel
    sazd_zcnt u_zl (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .tick_i    (q.tl),
        .zero_i    (q.left == 32'h00000000),
        .en_i      (en_l),
        .code_i    (q.thr[sazd_pkg::THR_L_LSB +: 3]),
        .hit_o     (hit_l)
    );
    sazd_zcnt u_zr (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .tick_i    (q.tr),
        .zero_i    (q.right == 32'h00000000),
        .en_i      (en_r),
        .code_i    (q.thr[sazd_pkg::THR_R_LSB +: 3]),
        .hit_o     (hit_r)
    );

    assign en_l = q.zctl[sazd_pkg::ZCTL_LEN];                      // see [R16]
    assign en_r = q.zctl[sazd_pkg::ZCTL_REN];                      // see [R15]

    // ========================================
    // Next state
    always_comb
    begin
        n     = q;
        fmt   = sazd_pkg::sazd_fmt_t'(q.fmt[sazd_pkg::FMT_LSB +: 2]);   // see [R09]
        wl    = sazd_pkg::WLEN[q.fmt[sazd_pkg::WL_LSB +: 2]];           // see [R03]
        wl7   = {1'b0, wl};
        tdm   = (fmt == sazd_pkg::SAZD_TDM);
        brise = lnk.bit_clock & ~q.bclk_l;                              // see [R02]
        wsr   = lnk.word_select_frame_sync & ~q.ws_l;
        shn   = {q.shr[30:0], lnk.serial_sample_input};                 // see [R01] see [R08]
        edg   = tdm ? (lnk.word_select_frame_sync & ~q.ws_b)            // see [R12]
                    : (lnk.word_select_frame_sync ^ q.ws_b);
        cn    = edg ? 7'h01 : ((q.bcnt == 7'h7F) ? q.bcnt : q.bcnt + 7'h01);
        src   = (fmt == sazd_pkg::SAZD_RJ) ? q.shr : shn;
        word  = q.resync ? 32'h00000000 : (src << (sazd_pkg::SAMP_W - wl));  // see [R19]
        n.bclk_l = lnk.bit_clock;
        n.ws_l   = lnk.word_select_frame_sync;
        n.tl     = 1'b0;
        n.tr     = 1'b0;
        n.vld    = 1'b0;

        // Word capture point per format
        case (fmt)
            sazd_pkg::SAZD_I2S: cap = (cn == wl7 + 7'h01);
            sazd_pkg::SAZD_LJ:  cap = (cn == wl7);
            sazd_pkg::SAZD_RJ:  cap = edg;
            default:            cap = (cn == wl7) | (cn == {wl, 1'b0});
        endcase
        // Channel of the captured word
        case (fmt)
            sazd_pkg::SAZD_I2S: chl = ~lnk.word_select_frame_sync;
            sazd_pkg::SAZD_LJ:  chl = lnk.word_select_frame_sync;
            sazd_pkg::SAZD_RJ:  chl = q.ws_b;
            default:            chl = (cn == wl7);
        endcase

        // Shift on each rising bit clock
        if (brise)
        begin
            n.bcnt = cn;
            n.shr  = shn;
            n.ws_b = lnk.word_select_frame_sync;
            n.bc   = (q.bc == 10'h3FF) ? q.bc : q.bc + 10'h001;
            if (cap & chl)
            begin
                n.left = word;
                n.tl   = 1'b1;
            end
            else if (cap)
            begin
                n.right = word;
                n.tr    = 1'b1;
                n.vld   = 1'b1;
            end
        end

        // Word clock period against system clock and bit clock
        n.per = (q.per == sazd_pkg::PER_MAX) ? q.per : q.per + 16'h0001;
        bad_s = (q.per == sazd_pkg::PER_MAX);
        bad_b = 1'b0;
        if (wsr)
        begin
            bad_s = ({1'b0, q.per} > {1'b0, q.per_ref} + sazd_pkg::SYNC_TOL) |
                    ({1'b0, q.per_ref} > {1'b0, q.per} + sazd_pkg::SYNC_TOL);  // see [R06]
            bad_b = (q.bc != q.bc_ref) & (q.bad >= sazd_pkg::INVALID_MAX);   // see [R07]
            n.bad = (q.bc == q.bc_ref) ? 3'h0 : ((q.bad == 3'h7) ? q.bad : q.bad + 3'h1);
            n.per_ref = q.per;
            n.per     = 16'h0001;
            n.bc_ref  = q.bc;
            n.bc      = {9'h000, brise};
        end
        fault = bad_s | bad_b;

        // Reinitialise on a fault, leave resync after good periods
        if (fault)
        begin
            n.resync = 1'b1;                                       // see [R06] see [R07]
            n.good   = 2'h0;
            n.bcnt   = 7'h7F;
        end
        else if (wsr & q.resync)
        begin
            n.good = q.good + 2'h1;
            if (n.good == sazd_pkg::RESYNC_GOOD)
                n.resync = 1'b0;
        end

        // Mute from combined channel triggers
        n.mute = q.zctl[sazd_pkg::ZCTL_AND]
               ? ((en_l | en_r) & (~en_l | hit_l) & (~en_r | hit_r))
               : ((en_l & hit_l) | (en_r & hit_r));                // see [R14] see [R18]

        // Master bit and word clock generation
        n.boe = q.mcfg[sazd_pkg::MCFG_EN] & q.mcfg[sazd_pkg::MCFG_BOUT];   // see [R11]
        n.woe = q.mcfg[sazd_pkg::MCFG_EN] & q.mcfg[sazd_pkg::MCFG_WOUT];
        n.gdiv = q.gdiv + 7'h01;
        if (!q.mcfg[sazd_pkg::MCFG_EN])
        begin
            n.gdiv = 7'h00;
            n.gb   = 1'b0;
            n.gw   = 8'h00;
            n.gws  = 1'b0;
        end
        else if (q.gdiv >= q.bdiv)
        begin
            n.gdiv = 7'h00;
            n.gb   = ~q.gb;                                        // see [R10]
            if (q.gb)
            begin
                n.gw  = (q.gw >= q.wdiv) ? 8'h00 : q.gw + 8'h01;
                n.gws = tdm ? (n.gw == 8'h00) : (n.gw <= {1'b0, q.wdiv[7:1]});
            end
        end

        // Wishbone access, one wait state
        hit   = wb_cyc_i & wb_stb_i & ~q.ack;
        idx   = wb_adr_i[sazd_pkg::ADR_LSB +: 8];
        n.ack = hit;
        if (hit & wb_we_i & wb_sel_i[0])
        begin
            case (idx)
                sazd_pkg::IDX_MCFG: n.mcfg = wb_dat_i[7:0];
                sazd_pkg::IDX_BDIV: n.bdiv = wb_dat_i[6:0];
                sazd_pkg::IDX_WDIV: n.wdiv = wb_dat_i[7:0];
                sazd_pkg::IDX_FMT:  n.fmt  = wb_dat_i[7:0] & 8'h33;
                sazd_pkg::IDX_THR:  n.thr  = wb_dat_i[7:0] & 8'h77;
                sazd_pkg::IDX_ZCTL: n.zctl = wb_dat_i[7:0] & 8'h07;
                sazd_pkg::IDX_MASK: n.mask = wb_dat_i[1:0];
                default:            n.ack  = hit;
            endcase
        end
        case (idx)
            sazd_pkg::IDX_MCFG: n.rdat = q.mcfg;
            sazd_pkg::IDX_BDIV: n.rdat = {1'b0, q.bdiv};
            sazd_pkg::IDX_WDIV: n.rdat = q.wdiv;
            sazd_pkg::IDX_FMT:  n.rdat = q.fmt;
            sazd_pkg::IDX_THR:  n.rdat = q.thr;
            sazd_pkg::IDX_ZCTL: n.rdat = q.zctl;
            sazd_pkg::IDX_STAT: n.rdat = {6'h00, q.mute, q.resync};    // see [R19]
            sazd_pkg::IDX_IRQ:  n.rdat = {6'h00, q.irq_st};
            sazd_pkg::IDX_MASK: n.rdat = {6'h00, q.mask};
            default:            n.rdat = 8'h00;
        endcase

        // Sticky events, read clears, new event wins
        ev       = {n.mute & ~q.mute, n.resync & ~q.resync};
        n.irq_st = ((hit & ~wb_we_i & (idx == sazd_pkg::IDX_IRQ)) ? 2'h0 : q.irq_st) | ev;
        n.irq    = |(n.irq_st & q.mask);
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q <= RST_ST;
        else
            q <= n;
    end

    // Outputs
    assign wb_dat_o             = {24'h000000, q.rdat};
    assign wb_ack_o             = q.ack;
    assign irq_o                = q.irq;
    assign left_o               = q.left;
    assign right_o              = q.right;
    assign sample_vld_o         = q.vld;
    assign mute_o               = q.mute;
    assign resync_o             = q.resync;
    assign lnk.bit_clock_dev    = q.gb;
    assign lnk.bit_clock_dev_oe = q.boe;
    assign lnk.word_sel_dev     = q.gws;
    assign lnk.word_sel_dev_oe  = q.woe;
endmodule : sazd_dev

// ---- sazd_host.sv ----
/*
 * Host end: serial audio transmitter in all four formats, optionally
 * generating bit and word clocks for a 64-bit frame.
 * Assumes the device does not drive clocks while master_i is high.
 */
`timescale 1ns/100ps
module sazd_host (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // Control
    input  wire logic        master_i,
    input  wire logic [1:0]  fmt_i,
    input  wire logic [1:0]  wlen_i,
    // Samples
    input  wire logic [31:0] left_i,
    input  wire logic [31:0] right_i,
    output logic             load_o,
    // Audio link
    sazd_if.host             lnk
);
    typedef struct packed {
        logic [3:0]  gdiv;
        logic        gb;
        logic [5:0]  gw;
        logic        gws;
        logic        bl;
        logic        wsf;
        logic [6:0]  pos;
        logic [6:0]  hlen;
        logic [31:0] lw;
        logic [31:0] rw;
        logic        dout;
        logic        load;
    } sazd_host_st_t;

    localparam sazd_host_st_t RST_ST = '{hlen: sazd_pkg::HOST_HLEN0, default: '0};

    sazd_host_st_t       q;
    sazd_host_st_t       n;
    sazd_pkg::sazd_fmt_t fmt;
    logic [6:0]          wl;
    logic [6:0]          pn;
    logic [6:0]          k;
    logic [31:0]         wrd;
    logic                tdm;
    logic                ws;
    logic                bfall;
    logic                chg;
    logic                lft;
    logic                ld;

    always_comb
    begin
        n     = q;
        fmt   = sazd_pkg::sazd_fmt_t'(fmt_i);
        wl    = {1'b0, sazd_pkg::WLEN[wlen_i]};                    // see [R03]
        tdm   = (fmt == sazd_pkg::SAZD_TDM);
        ws    = lnk.word_select_frame_sync;
        bfall = ~lnk.bit_clock & q.bl;
        chg   = tdm ? (ws & ~q.wsf) : (ws ^ q.wsf);                // see [R12]
        pn    = chg ? 7'h00 : ((q.pos == 7'h7F) ? q.pos : q.pos + 7'h01);
        lft   = (fmt == sazd_pkg::SAZD_I2S) ? ~ws : ws;
        ld    = chg & (tdm | lft);
        n.bl   = lnk.bit_clock;
        n.load = 1'b0;

        // Bit position within the current word
        case (fmt)
            sazd_pkg::SAZD_I2S: k = pn - 7'h01;
            sazd_pkg::SAZD_RJ:  k = pn - (q.hlen - wl);
            sazd_pkg::SAZD_TDM: k = (pn < wl) ? pn : pn - wl;
            default:            k = pn;
        endcase
        if (tdm)
            wrd = (pn < wl) ? (ld ? left_i : q.lw) : q.rw;
        else
            wrd = lft ? (ld ? left_i : q.lw) : q.rw;

        // Data changes on the falling bit clock, MSB first
        if (bfall)
        begin
            n.wsf = ws;
            n.pos = pn;
            if (chg & ~tdm)
                n.hlen = q.pos + 7'h01;
            if (ld)
            begin
                n.lw   = left_i;
                n.rw   = right_i;
                n.load = 1'b1;
            end
            n.dout = (k < wl) & (!tdm | (pn < {wl[5:0], 1'b0}))
                   & wrd[5'(wl - 7'h01 - k)];                      // see [R02] see [R08]
        end

        // Clocks in master role
        n.gdiv = q.gdiv + 4'h1;
        if (!master_i)
        begin
            n.gdiv = 4'h0;
            n.gb   = 1'b0;
            n.gw   = 6'h00;
            n.gws  = 1'b0;
        end
        else if (q.gdiv == sazd_pkg::HOST_HALF - 4'h1)             // see [R04]
        begin
            n.gdiv = 4'h0;
            n.gb   = ~q.gb;                                        // see [R05]
            if (q.gb)
            begin
                n.gw  = q.gw + 6'h01;
                n.gws = tdm ? (n.gw == 6'h00) : (n.gw <= sazd_pkg::HOST_WSH);
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q <= RST_ST;
        else
            q <= n;
    end

    // Outputs
    assign load_o                  = q.load;
    assign lnk.bit_clock_host      = q.gb;
    assign lnk.word_sel_host       = q.gws;
    assign lnk.serial_sample_input = q.dout;                       // see [R01]
endmodule : sazd_host

// ---- sazd_monitor.sv ----
/* Wire-level checks on the host to device audio link.
   Assumes the bench feeds it the resolved link wires. */
`timescale 1ns/100ps
module sazd_monitor (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Link wires
    input wire logic bit_clock,
    input wire logic word_select_frame_sync,
    input wire logic serial_sample_input
);
    // ============================
    // Link timing
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // Bit clock phases last exactly two system cycles
    chk_bclk_high: assert property ($rose(bit_clock) |=> bit_clock ##1 !bit_clock)
        else $error("bit clock high phase wrong");
    chk_bclk_low: assert property ($fell(bit_clock) |=> !bit_clock ##1 bit_clock)
        else $error("bit clock low phase wrong");
    // Data moves only while the bit clock is low, once per bit
    chk_data_low: assert property ($changed(serial_sample_input) |-> !bit_clock)
        else $error("data moved with bit clock high");
    chk_data_hold: assert property ($changed(serial_sample_input) |=>
        $stable(serial_sample_input) [*3]) else $error("data bit too short");
    // Word clock edges sit in the low phase and last at least one bit
    chk_ws_edge: assert property ($changed(word_select_frame_sync) |-> !bit_clock)
        else $error("word clock moved with bit clock high");
    chk_fs_high: assert property ($rose(word_select_frame_sync) |->
        word_select_frame_sync [*4]) else $error("frame sync shorter than a bit");
    chk_ws_low: assert property ($fell(word_select_frame_sync) |->
        !word_select_frame_sync [*4]) else $error("word clock low shorter than a bit");
    chk_ws_bound: assert property ($rose(word_select_frame_sync) |->
        ##[1:300] $fell(word_select_frame_sync)) else $error("word clock stuck high");
    // Main scenarios reached
    cov_frame: cover property ($rose(word_select_frame_sync));
    cov_bits: cover property ($changed(serial_sample_input) ##4 $changed(serial_sample_input));
    cov_bclk: cover property ($rose(bit_clock) ##4 $rose(bit_clock));
endmodule : sazd_monitor

// ---- tb.sv ----
/* Bench joining host end and device end over the audio link.
   Assumes design files and checker compile first. */
`timescale 1ns/100ps
module tb;
    typedef struct packed {logic [1:0] fmt; logic [1:0] wl; logic [31:0] l; logic [31:0] r;} sazd_row_t;
    logic        sys_clk_i, nrst_i, cyc, we, master, ack, irq_o, vld, mute_o, resync_o, pb;
    logic [1:0]  fmt, wl;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat, rd, left_o, right_o, l_in, r_in;
    int          miscompares, total_checks, n, sh;
    sazd_row_t   rows [4] = '{'{2'h0, 2'h0, 32'h00008001, 32'h00007FFE},
                              '{2'h1, 2'h1, 32'h000FFFFF, 32'h00080000},
                              '{2'h2, 2'h2, 32'h00800001, 32'h007FFFFF},
                              '{2'h3, 2'h3, 32'h80000001, 32'hFFFFFFFE}};
    logic [7:0]  ridx [4] = '{sazd_pkg::IDX_FMT, sazd_pkg::IDX_ZCTL, sazd_pkg::IDX_THR, 8'h7F};
    logic [31:0] rexp [4] = '{32'h02, 32'h07, 32'h00, 32'h00};

    // ============================
    // Ends and checker
    sazd_if lnk ();
    sazd_dev u_sazd_dev (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq_o), .left_o(left_o), .right_o(right_o),
        .sample_vld_o(vld), .mute_o(mute_o), .resync_o(resync_o), .lnk(lnk));
    sazd_host u_sazd_host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .master_i(master),
        .fmt_i(fmt), .wlen_i(wl), .left_i(l_in), .right_i(r_in), .load_o(), .lnk(lnk));
    sazd_monitor u_sazd_monitor (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .bit_clock(lnk.bit_clock), .word_select_frame_sync(lnk.word_select_frame_sync),
        .serial_sample_input(lnk.serial_sample_input));

    // Clock at 25 MHz
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // ============================
    // Shared tasks
    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One classic Wishbone cycle, entered after a rising edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        int k;
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            miscompares++;
            tally_and_finish();
        end
        q = rdat;
        cyc <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wb

    // Bounded wait on resync (0), sample valid (1) or interrupt (2)
    task automatic await(input int s, input logic v);
        int k;
        k = 0;
        while ((s == 0 ? resync_o : s == 1 ? vld : irq_o) !== v)
        begin
            @(posedge sys_clk_i);
            k++;
            if (k > 5000)
            begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask : await

    // ============================
    // Main sequence
    initial
    begin
        {nrst_i, cyc, we, adr, wdat, fmt, l_in, r_in} = '0;
        {master, wl, miscompares, total_checks} = {1'b1, 2'h2, 64'h0};
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        // Reset values, unmapped read, combine bit write back
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b0, ridx[i], 8'h00, rd);
            check(rd, rexp[i], "reg reset");
        end
        wb(1'b1, sazd_pkg::IDX_ZCTL, 8'h03, rd);
        wb(1'b0, sazd_pkg::IDX_ZCTL, 8'h00, rd);
        check(rd, 32'h03, "zctl");
        // Every format and word length
        for (int i = 0; i < 4; i++)
        begin
            {fmt, wl, l_in, r_in} <= rows[i];
            wb(1'b1, sazd_pkg::IDX_FMT, {2'h0, rows[i].fmt, 2'h0, rows[i].wl}, rd);
            repeat (6)
            begin
                @(posedge sys_clk_i);
                await(1, 1'b1);
            end
            sh = (rows[i].wl == 2'h3) ? 0 : 16 - 4 * rows[i].wl;
            check(left_o, rows[i].l << sh, "left");
            check(right_o, rows[i].r << sh, "right");
            check({31'h0, mute_o}, 32'h0, "mute");
        end
        // Device master, then word clock period fault
        master <= 1'b0;
        nrst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        wb(1'b1, sazd_pkg::IDX_MASK, 8'h01, rd);
        wb(1'b1, sazd_pkg::IDX_MCFG, 8'h31, rd);
        {n, pb} = '0;
        repeat (400)
        begin
            @(posedge sys_clk_i);
            n += int'(lnk.bit_clock === 1'b1 && !pb);
            pb = lnk.bit_clock;
        end
        check(32'(n >= 99 && n <= 101), 32'h1, "bclk rises");
        await(0, 1'b0);
        check({31'h0, irq_o}, 32'h0, "irq idle");
        wb(1'b1, sazd_pkg::IDX_WDIV, 8'h1F, rd);
        await(2, 1'b1);
        check({31'h0, resync_o}, 32'h1, "resync");
        wb(1'b0, sazd_pkg::IDX_IRQ, 8'h00, rd);
        check(rd, 32'h01, "irq status");
        repeat (2) @(posedge sys_clk_i);
        check({31'h0, irq_o}, 32'h0, "irq cleared");
        tally_and_finish();
    end
endmodule : tb
